// >>> rtl/demod_stream_consts.vh
// Constants for the demodulator sample trigger and streaming block.
// Assumes inclusion by bare name from the design files.
`ifndef DEMOD_STREAM_CONSTS_VH
`define DEMOD_STREAM_CONSTS_VH
// Register byte offsets on the register bus.
`define OFS_CTRL      12'h000
`define OFS_LOCK      12'h004
`define OFS_STATUS    12'h008
`define OFS_SEL_DEMOD 12'h00C
`define OFS_RATE_DIV  12'h010
`define OFS_DATA      12'h014
`define OFS_SRC_CFG   12'h018
`define OFS_AUX_DIV   12'h01C
// Trigger source codes.
`define SRC_CONT      3'h0
`define SRC_EXT_A     3'h1
`define SRC_EXT_B     3'h2
`define SRC_EXT_OR    3'h3
`define SRC_GEN1      3'h4
`define SRC_GEN2      3'h5
`define SRC_GEN3      3'h6
`define SRC_GEN4      3'h7
// Trigger condition codes.
`define COND_RISE     3'h0
`define COND_FALL     3'h1
`define COND_BOTH     3'h2
`define COND_HIGH     3'h3
`define COND_LOW      3'h4
// Rate divider limits: 125 MHz clock, 14 MSa/s down to 0.42 Sa/s.
`define CLK_HZ        125000000
`define RATE_MAX_HZ   14000000
`define RATE_MIN_MHZ  420
`define DIV_MIN       32'h00000009
`define DIV_MAX       32'h11BD4E67
`define DIV_RESET     32'h000004E2
`define AUX_RESET     32'h00000100
// Field positions.
`define CTRL_EN_LSB   0
`define LOCK_BIT      0
`define CFG_SRC_LSB   0
`define CFG_COND_LSB  4
`endif

// >>> rtl/sample_fifo.v
// Sample FIFO: flip-flop storage, valid and ready on both sides.
// Assumes a single clock and an active low asynchronous reset.
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset.
  input  wire             mclk_in,
  input  wire             reset_n_in,
  // Fill side.
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  // Drain side.
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out,
  // Fill level.
  output wire [AW:0]      level_out
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wptr_ff;
  reg [AW-1:0]    rptr_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;

  // Full and empty come straight from the count, so they never lie.
  assign wr_ready_out = (cnt_ff != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_ff != {(AW+1){1'b0}});
  assign rd_data_out  = mem_ff[rptr_ff];
  assign level_out    = cnt_ff;
  assign push         = wr_valid_in & wr_ready_out;
  assign pop          = rd_valid_out & rd_ready_in;

  // Pointers wrap at the depth, which need not be a power of two.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      cnt_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                   wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                   rptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // Storage has no reset; empty entries are never presented.
  always @(posedge mclk_in) begin
    if (push) begin
      mem_ff[wptr_ff] <= wr_data_in;
    end
  end
endmodule

// >>> rtl/demod_sample_trigger_stream.v
// Demodulator sample trigger and streaming control with APB registers.
// Assumes demodulators present samples each clock, host drains a stream.
// Functional notes
// RL1 - Each demodulator streams only while its own enable bit is set.
// RL2 - Per-demodulator sample rate programmable from 0.42 Sa/s to 14 MSa/s.
// RL3 - Unreachable requested rates snap to the nearest supported divider.
// RL4 - Host stream rate is independent of the auxiliary output update rate.
// RL5 - Setting rate lock copies demodulator 1 rate to all demodulators.
// RL6 - While locked, any rate write goes to all demodulators alike.
// RL7 - Clearing rate lock leaves all rate values unchanged.
// RL8 - Continuous mode streams without pause at the programmed rate.
// RL9 - Source selector offers external triggers three and four singly.
// RL10 - One source selection uses OR of external triggers three and four.
// RL11 - Source selector offers the four generator trigger outputs.
// RL12 - Edge condition sends one sample per rising, falling or either edge.
// RL13 - Under any edge condition the programmed rate has no effect.
// RL14 - Level condition streams while trigger is high, or while low.
// RL15 - While the level gate is active samples follow the programmed rate.
// RL16 - Trigger condition is ignored when the continuous source is chosen.
// RL17 - External triggers are synchronised, edges from consecutive values.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "demod_stream_consts.vh"
module demod_sample_trigger_stream #(
  parameter NUM_DEMOD = 8,
  parameter IDX_W     = 3,
  parameter DATA_W    = 32,
  parameter FIFO_D    = 8,
  parameter FIFO_AW   = 3
) (
  // Clock and reset.
  input  wire                        mclk_in,
  input  wire                        reset_n_in,
  // APB slave.
  input  wire                        psel_in,
  input  wire                        penable_in,
  input  wire                        pwrite_in,
  input  wire [11:0]                 paddr_in,
  input  wire [31:0]                 pwdata_in,
  output reg  [31:0]                 prdata_out,
  output wire                        pready_out,
  output wire                        pslverr_out,
  // Trigger sources.
  input  wire                        ext_trig_a_in,
  input  wire                        ext_trig_b_in,
  input  wire [3:0]                  gen_trig_in,
  // Demodulator samples, one word per demodulator.
  input  wire [NUM_DEMOD*DATA_W-1:0] demod_data_in,
  // Host stream.
  output wire                        host_valid_out,
  input  wire                        host_ready_in,
  output wire [DATA_W+IDX_W-1:0]     host_data_out,
  // Auxiliary output update strobe, own divider.
  output reg                         aux_update_out
);
  localparam PKT_W = DATA_W + IDX_W;

  // Register state.
  reg [NUM_DEMOD-1:0]  en_ff;
  reg                  lock_ff;
  reg [IDX_W-1:0]      sel_ff;
  reg [31:0]           div_ff [0:NUM_DEMOD-1];
  reg [2:0]            src_ff [0:NUM_DEMOD-1];
  reg [2:0]            cond_ff [0:NUM_DEMOD-1];
  reg [31:0]           aux_div_ff;
  reg [31:0]           aux_cnt_ff;
  reg [31:0]           drop_cnt_ff;
  // Trigger synchronisers and history.
  reg [1:0]            sync_a_ff;
  reg [1:0]            sync_b_ff;
  reg [3:0]            gen_prev_ff;
  reg                  ext_a_prev_ff;
  reg                  ext_b_prev_ff;
  // Per-demodulator pacing and pending requests.
  reg [31:0]           rate_cnt_ff [0:NUM_DEMOD-1];
  reg [NUM_DEMOD-1:0]  pend_ff;
  reg [DATA_W-1:0]     cap_ff [0:NUM_DEMOD-1];
  reg [IDX_W-1:0]      rr_ff;

  wire                 wr_acc;
  wire                 rd_setup;
  wire [31:0]          wdiv;
  wire [NUM_DEMOD-1:0] want;
  wire                 fifo_ready;
  wire [FIFO_AW:0]     fifo_level;
  wire                 ext_a;
  wire                 ext_b;
  wire [7:0]           cur_lvl;
  wire [7:0]           prev_lvl;
  reg                  push_valid;
  reg  [PKT_W-1:0]     push_data;
  reg  [IDX_W-1:0]     push_idx;
  reg                  found;
  reg  [31:0]          nxt_prdata;
  // Each process owns its loop index, so no variable has two drivers.
  integer              k;
  integer              j;
  integer              m;

  // Zero-wait slave; unmapped addresses read zero and report no error.
  // A read is looked up in its setup cycle, so that the word is already
  // in a flop when the access cycle begins and no wait state is needed.
  assign pready_out  = 1'b1;
  assign pslverr_out = 1'b0;
  assign wr_acc      = psel_in & penable_in & pwrite_in;
  assign rd_setup    = psel_in & ~penable_in & ~pwrite_in;

  // Clamp the requested divider to the supported rate range, DIV_MIN to DIV_MAX.
  assign wdiv = (pwdata_in < `DIV_MIN) ? `DIV_MIN :
                (pwdata_in > `DIV_MAX) ? `DIV_MAX : pwdata_in; // RL2 RL3

  // Only the second flop of each synchroniser feeds logic.
  assign ext_a = sync_a_ff[1]; // RL17
  assign ext_b = sync_b_ff[1]; // RL17
  // Source values indexed by source code, current and previous cycle.
  // Generator triggers come from logic on this clock and need no sync.
  assign cur_lvl  = {gen_trig_in, ext_a | ext_b, ext_b, ext_a, 1'b1};
  assign prev_lvl = {gen_prev_ff, ext_a_prev_ff | ext_b_prev_ff,
                     ext_b_prev_ff, ext_a_prev_ff, 1'b1}; // RL9 RL10 RL11

  // Synchronise external triggers and keep one cycle of history.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a_ff     <= 2'h0;
      sync_b_ff     <= 2'h0;
      ext_a_prev_ff <= 1'b0;
      ext_b_prev_ff <= 1'b0;
      gen_prev_ff   <= 4'h0;
    end else begin
      sync_a_ff     <= {sync_a_ff[0], ext_trig_a_in}; // RL17
      sync_b_ff     <= {sync_b_ff[0], ext_trig_b_in}; // RL17
      ext_a_prev_ff <= ext_a; // RL17
      ext_b_prev_ff <= ext_b;
      gen_prev_ff   <= gen_trig_in;
    end
  end

  // Per-demodulator decision: whether a sample is wanted this cycle.
  genvar g;
  generate
    for (g = 0; g < NUM_DEMOD; g = g + 1) begin : g_demod
      wire       cur;
      wire       prv;
      wire       tick;
      wire       is_cont;
      wire       edge_hit;
      reg        gate;
      reg        fire;
      assign cur     = cur_lvl[src_ff[g]];
      assign prv     = prev_lvl[src_ff[g]];
      assign tick    = (rate_cnt_ff[g] == 32'h00000000);
      assign is_cont = (src_ff[g] == `SRC_CONT);
      assign edge_hit = (cur != prv);

      // Condition decode; ignored altogether under the continuous source.
      always @* begin
        gate = 1'b0;
        fire = 1'b0;
        if (is_cont) begin
          gate = 1'b1; // RL8 RL16
          fire = tick; // RL8
        end else begin
          case (cond_ff[g])
            `COND_RISE: fire = edge_hit & cur; // RL12 RL13
            `COND_FALL: fire = edge_hit & ~cur; // RL12 RL13
            `COND_BOTH: fire = edge_hit; // RL12 RL13
            `COND_HIGH: begin
              gate = cur; // RL14
              fire = cur & tick; // RL15
            end
            `COND_LOW: begin
              gate = ~cur; // RL14
              fire = ~cur & tick; // RL15
            end
            default: fire = 1'b0;
          endcase
        end
      end
      assign want[g] = en_ff[g] & fire; // RL1

      // Pacing counter restarts whenever the gate is shut or disabled.
      // The first paced sample therefore comes one full period after the
      // gate opens; a gate shorter than one period emits nothing.
      always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          rate_cnt_ff[g] <= 32'h00000000;
          cap_ff[g]      <= {DATA_W{1'b0}};
        end else begin
          if (!en_ff[g] || !gate || tick) begin
            rate_cnt_ff[g] <= div_ff[g] - 32'h00000001; // RL15
          end else begin
            rate_cnt_ff[g] <= rate_cnt_ff[g] - 32'h00000001;
          end
          if (want[g]) begin
            cap_ff[g] <= demod_data_in[g*DATA_W +: DATA_W];
          end
        end
      end
    end
  endgenerate

  // Round-robin pick of one pending sample per cycle into the FIFO.
  always @* begin
    push_valid = 1'b0;
    push_idx   = {IDX_W{1'b0}};
    found      = 1'b0;
    for (k = 0; k < NUM_DEMOD; k = k + 1) begin
      if (!found && pend_ff[(rr_ff + k) % NUM_DEMOD]) begin
        found      = 1'b1;
        push_valid = 1'b1;
        push_idx   = (rr_ff + k[IDX_W-1:0]);
      end
    end
    push_data = {push_idx, cap_ff[push_idx]};
  end

  // Pending flags: a new request wins over the clear of a push.
  // A cycle in which any request finds its flag already set, unless that flag is pushed in the same cycle, adds one to the drop count.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_ff     <= {NUM_DEMOD{1'b0}};
      rr_ff       <= {IDX_W{1'b0}};
      drop_cnt_ff <= 32'h00000000;
    end else begin
      for (j = 0; j < NUM_DEMOD; j = j + 1) begin
        if (want[j]) begin
          pend_ff[j] <= 1'b1;
        end else if (push_valid && fifo_ready && push_idx == j) begin
          pend_ff[j] <= 1'b0;
        end
      end
      if (push_valid && fifo_ready) begin
        rr_ff <= push_idx + 1'b1;
      end
      if (|(want & pend_ff & ~({NUM_DEMOD{push_valid & fifo_ready}}
          & ({{(NUM_DEMOD-1){1'b0}}, 1'b1} << push_idx)))) begin
        drop_cnt_ff <= drop_cnt_ff + 32'h00000001;
      end
    end
  end

  // Register writes, including the rate lock behaviour.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_ff      <= {NUM_DEMOD{1'b0}};
      lock_ff    <= 1'b0;
      sel_ff     <= {IDX_W{1'b0}};
      aux_div_ff <= `AUX_RESET;
      for (m = 0; m < NUM_DEMOD; m = m + 1) begin
        div_ff[m]  <= `DIV_RESET;
        src_ff[m]  <= `SRC_CONT;
        cond_ff[m] <= `COND_RISE;
      end
    end else if (wr_acc) begin
      case (paddr_in)
        `OFS_CTRL: en_ff <= pwdata_in[`CTRL_EN_LSB +: NUM_DEMOD]; // RL1
        `OFS_LOCK: begin
          // Only the rising lock copies; rewriting a set lock changes nothing.
          lock_ff <= pwdata_in[`LOCK_BIT]; // RL7
          if (pwdata_in[`LOCK_BIT] && !lock_ff) begin
            for (m = 1; m < NUM_DEMOD; m = m + 1) begin
              div_ff[m] <= div_ff[0]; // RL5
            end
          end
        end
        `OFS_SEL_DEMOD: sel_ff <= pwdata_in[IDX_W-1:0];
        `OFS_RATE_DIV: begin
          if (lock_ff) begin
            for (m = 0; m < NUM_DEMOD; m = m + 1) begin
              div_ff[m] <= wdiv; // RL6
            end
          end else begin
            div_ff[sel_ff] <= wdiv; // RL2
          end
        end
        `OFS_SRC_CFG: begin
          src_ff[sel_ff]  <= pwdata_in[`CFG_SRC_LSB +: 3];
          cond_ff[sel_ff] <= pwdata_in[`CFG_COND_LSB +: 3];
        end
        `OFS_AUX_DIV: aux_div_ff <= (pwdata_in == 32'h00000000) ?
                                    32'h00000001 : pwdata_in; // RL4
        default: lock_ff <= lock_ff;
      endcase
    end
  end

  // Auxiliary update strobe paced by its own divider, not the stream rate.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aux_cnt_ff     <= 32'h00000000;
      aux_update_out <= 1'b0;
    end else begin
      aux_update_out <= (aux_cnt_ff == 32'h00000000); // RL4
      if (aux_cnt_ff == 32'h00000000) begin
        aux_cnt_ff <= aux_div_ff - 32'h00000001;
      end else begin
        aux_cnt_ff <= aux_cnt_ff - 32'h00000001;
      end
    end
  end

  // Read mux, looked up during the setup cycle. Status and drop count are
  // therefore one cycle old when the access cycle shows them; that is the
  // price of a flopped read word with no wait state.
  always @* begin
    nxt_prdata = 32'h00000000;
    if (rd_setup) begin
      case (paddr_in)
        `OFS_CTRL:      nxt_prdata = {{(32-NUM_DEMOD){1'b0}}, en_ff};
        `OFS_LOCK:      nxt_prdata = {31'h00000000, lock_ff};
        `OFS_STATUS:    nxt_prdata = {{(16-NUM_DEMOD){1'b0}}, pend_ff,
                                      {(16-FIFO_AW-1){1'b0}}, fifo_level};
        `OFS_SEL_DEMOD: nxt_prdata = {{(32-IDX_W){1'b0}}, sel_ff};
        `OFS_RATE_DIV:  nxt_prdata = div_ff[sel_ff];
        `OFS_DATA:      nxt_prdata = drop_cnt_ff;
        `OFS_SRC_CFG:   nxt_prdata = {25'h0000000, cond_ff[sel_ff],
                                      1'b0, src_ff[sel_ff]};
        `OFS_AUX_DIV:   nxt_prdata = aux_div_ff;
        default:        nxt_prdata = 32'h00000000;
      endcase
    end
  end

  // The word stands through the access cycle and falls back to zero after
  // it, so an idle bus never shows stale register contents.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h00000000;
    end else begin
      prdata_out <= nxt_prdata;
    end
  end

  // Output buffer toward the host; a stalled host backs up the pending
  // flags, and further requests for a still pending demodulator drop.
  sample_fifo #(
    .WIDTH (PKT_W),
    .DEPTH (FIFO_D),
    .AW    (FIFO_AW)
  ) u_fifo (
    .mclk_in      (mclk_in),
    .reset_n_in   (reset_n_in),
    .wr_valid_in  (push_valid),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (push_data),
    .rd_valid_out (host_valid_out),
    .rd_ready_in  (host_ready_in),
    .rd_data_out  (host_data_out),
    .level_out    (fifo_level)
  );
endmodule

// >>> tb/stream_chk_sva.sv
// Checker for the sample trigger stream block, fed by top ports only.
// Assumes a bind from the bench and an aux divider left at its default.
`timescale 1ns/1ps
module stream_chk (
  // Clock, reset and register bus.
  input wire        mclk_in,
  input wire        reset_n_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  // Host stream and aux strobe.
  input wire        host_valid_out,
  input wire        host_ready_in,
  input wire [34:0] host_data_out,
  input wire        aux_update_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  wire       acc = psel_in && penable_in;
  wire       wr  = acc && pwrite_in;
  wire       rd  = acc && !pwrite_in;
  reg  [7:0] ctrl_sh_ff;
  reg        lock_sh_ff;
  // Shadow copies let the read path be judged without peeking inside.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_sh_ff <= 8'h00;
      lock_sh_ff <= 1'b0;
    end else begin
      if (wr && paddr_in == 12'h000) ctrl_sh_ff <= pwdata_in[7:0];
      if (wr && paddr_in == 12'h004) lock_sh_ff <= pwdata_in[0];
    end
  end
  // A stalled word is one that the host has not yet taken.
  sequence s_stall;
    host_valid_out && !host_ready_in;
  endsequence
  property p_ready; pready_out; endproperty
  property p_noerr; !pslverr_out; endproperty
  property p_idle_rd; !acc |-> prdata_out == 32'h0; endproperty
  property p_unmapped; rd && paddr_in == 12'h020 |-> prdata_out == 32'h0;
  endproperty
  property p_ctrl_rd;
    rd && paddr_in == 12'h000 |-> prdata_out[7:0] == ctrl_sh_ff;
  endproperty
  property p_lock_rd;
    rd && paddr_in == 12'h004 |-> prdata_out[0] == lock_sh_ff;
  endproperty
  property p_hold;
    s_stall |=> host_valid_out && $stable(host_data_out);
  endproperty
  property p_aux;
    aux_update_out |=> !aux_update_out [*8] ##248 aux_update_out;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_noerr: assert property (p_noerr) else $error("pslverr high");
  a_idle_rd: assert property (p_idle_rd) else $error("idle read data");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("enable readback");
  a_lock_rd: assert property (p_lock_rd) else $error("lock readback");
  a_hold: assert property (p_hold) else $error("stream word dropped");
  a_aux: assert property (p_aux) else $error("aux period wrong");
endmodule

// >>> tb/host_sink.sv
// Host side model: takes stream words, stalls at random or on command.
// Assumes the block holds valid and data until a word is taken.
`timescale 1ns/1ps
module host_sink (
  input  wire  mclk_in,
  input  wire  reset_n_in,
  input  wire  hold_in,
  output logic ready_out
);
  // Random back pressure proves the block waits for acceptance.
  always @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in) ready_out <= 1'b0;
    else ready_out <= !hold_in && ($urandom % 4 != 0);
endmodule

// >>> tb/tb.sv
// Bench for the sample trigger stream block: registers, modes, buffer.
// Assumes the checker and host model are compiled before this file.
`timescale 1ns/1ps
`include "demod_stream_consts.vh"
module tb;
  logic         mclk_in = 0, reset_n_in = 0, hold = 0;
  logic         psel = 0, penable = 0, pwrite = 0, ext_a = 0, ext_b = 0;
  logic         pready, pslverr, hv, hr, aux;
  logic [3:0]   gen = 4'h0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, r;
  logic [31:0]  tv [6];
  logic [255:0] dd = 256'h0;
  logic [34:0]  hd;
  int           fails = 0, total_checks = 0, got = 0, cyc = 0, g0, n;
  always #4 mclk_in = ~mclk_in;
  demod_sample_trigger_stream i_demod_sample_trigger_stream (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .ext_trig_a_in(ext_a), .ext_trig_b_in(ext_b),
    .gen_trig_in(gen), .demod_data_in(dd), .host_valid_out(hv),
    .host_ready_in(hr), .host_data_out(hd), .aux_update_out(aux));
  host_sink i_host_sink (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .hold_in(hold), .ready_out(hr));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Paced counts may land one off, since the gate phase is not known.
  task automatic near(input int g, input int e);
    total_checks++;
    if (g < e - 1 || g > e + 1) begin
      fails++;
      $display("Error at %0t: count %0d expected %0d", $time, g, e);
    end
  endtask
  function automatic int edges(input int c, input int k);
    return (c == 2) ? 2 * k : k;
  endfunction
  function automatic logic [31:0] clamp(input logic [31:0] v);
    return v < `DIV_MIN ? `DIV_MIN : (v > `DIV_MAX ? `DIV_MAX : v);
  endfunction
  // Every accepted word must carry the sample of the index it names.
  always @(posedge mclk_in) begin
    cyc++;
    if (reset_n_in && hv === 1'b1 && hr === 1'b1) begin
      got++;
      chk(hd[31:0], dd[hd[34:32]*32 +: 32]);
    end
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge mclk_in);
  endtask
  // Setup, then access until ready; the idle edge after it keeps a
  // following transfer from assigning the strobes in the same step.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1;
    @(posedge mclk_in);
    while (pready !== 1'b1) @(posedge mclk_in);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic start(input logic [7:0] en);
    g0 = got;
    wr(`OFS_CTRL, {24'h0, en});
  endtask
  task automatic stop();
    wr(`OFS_CTRL, 32'h0);
    wait_cyc(60);
    n = got - g0;
  endtask
  // Source three alternates its pulses between both external inputs.
  task automatic drive(input int s, input logic v, input int k);
    if (s == 1 || (s == 3 && k % 2 == 0)) ext_a <= v;
    if (s == 2 || (s == 3 && k % 2 == 1)) ext_b <= v;
    if (s >= 4) gen[s-4] <= v;
  endtask
  initial begin
    r = $urandom(32'hEF1C);
    @(posedge mclk_in);
    for (int i = 0; i < 8; i++) dd[i*32 +: 32] <= $urandom;
    wait_cyc(19);
    reset_n_in <= 1;
    @(posedge mclk_in);
    rdc(`OFS_CTRL, 32'h0);
    rdc(`OFS_RATE_DIV, `DIV_RESET);
    rdc(`OFS_AUX_DIV, `AUX_RESET);
    rdc(`OFS_SRC_CFG, 32'h0);
    rdc(12'h020, 32'h0);
    $display("reset values done");
    tv = '{32'h0, 32'h8, 32'h9, 32'h9 + $urandom % 1000,
           `DIV_MAX + 32'h1, 32'hFFFFFFFF};
    foreach (tv[i]) begin
      wr(`OFS_RATE_DIV, tv[i]);
      rdc(`OFS_RATE_DIV, clamp(tv[i]));
    end
    $display("rate clamp done");
    wr(`OFS_RATE_DIV, 50);
    wr(`OFS_SEL_DEMOD, 3);
    wr(`OFS_RATE_DIV, 70);
    wr(`OFS_LOCK, 1);
    rdc(`OFS_RATE_DIV, 50);
    wr(`OFS_SEL_DEMOD, 5);
    wr(`OFS_RATE_DIV, 60);
    wr(`OFS_SEL_DEMOD, 0);
    rdc(`OFS_RATE_DIV, 60);
    wr(`OFS_LOCK, 0);
    rdc(`OFS_RATE_DIV, 60);
    wr(`OFS_RATE_DIV, 40);
    wr(`OFS_SEL_DEMOD, 5);
    rdc(`OFS_RATE_DIV, 60);
    $display("rate lock done");
    wr(`OFS_SEL_DEMOD, 2);
    wr(`OFS_RATE_DIV, 20);
    wr(`OFS_SRC_CFG, 32'h30);
    start(8'h04);
    wait_cyc(398);
    stop();
    near(n, 400 / 20);
    $display("continuous done");
    wr(`OFS_SEL_DEMOD, 1);
    wr(`OFS_RATE_DIV, 9);
    for (int s = 1; s < 8; s++)
      for (int c = 0; c < 3; c++) begin
        wr(`OFS_SRC_CFG, 32'(c * 16 + s));
        start(8'h02);
        for (int k = 0; k < 3; k++) begin
          drive(s, 1'b1, k);
          wait_cyc(20);
          drive(s, 1'b0, k);
          wait_cyc(20);
        end
        stop();
        chk(n, edges(c, 3));
      end
    $display("edge triggers done");
    wr(`OFS_SEL_DEMOD, 0);
    wr(`OFS_RATE_DIV, 10);
    for (int c = 3; c < 5; c++) begin
      wr(`OFS_SRC_CFG, 32'(c * 16 + 4));
      gen[0] <= (c == 4);
      start(8'h01);
      wait_cyc(100);
      gen[0] <= (c == 3);
      wait_cyc(200);
      gen[0] <= (c == 4);
      wait_cyc(100);
      stop();
      near(n, 200 / 10);
    end
    gen[0] <= 0;
    $display("level gating done");
    hold <= 1;
    wr(`OFS_SRC_CFG, 32'h0);
    start(8'hFF);
    wait_cyc(200);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(r[7:0], 8'h08);
    apb(1'b0, `OFS_DATA, 32'h0);
    chk(r != 0, 1);
    hold <= 0;
    stop();
    wait_cyc(100);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(r[7:0], 8'h00);
    $display("buffer fill and drain done");
    wrap_up();
  end
endmodule
bind demod_sample_trigger_stream stream_chk i_stream_chk (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .host_valid_out(host_valid_out), .host_ready_in(host_ready_in),
  .host_data_out(host_data_out), .aux_update_out(aux_update_out));
